// ### design/qrsp_pkg.sv
// How it works
// [R1] Write data captured on both clock phases
// [R2] Low write select sampled starts write
// [R3] Deselected write port ignores data input
// [R4] Byte selects decide which bytes store
// [R5] Unselected bytes stay unchanged in array
// [R6] Select n controls 9-bit lane n
// [R7] Byte selects sampled with their beat
// [R8] Deasserted byte select drops that byte
// [R9] Shared address sampled on positive edge
// [R10] 17 address bits, four 128K arrays
// [R11] Address ignored when port deselected
// [R12] Read data driven on both phases
// [R13] Deselected read port tristates outputs
// [R14] Low read select starts four-beat burst
// [R15] Pending read completes, then tristate
// [R16] Valid flag marks driven read data
// [R17] Write is four beats over two cycles
// [R18] Controller alternates read/write addresses; the core takes both read and write addresses on the positive edge only
`default_nettype none
package qrsp_pkg;
    localparam int DATA_W = 36;
    localparam int LANES = 4;
    localparam int LANE_W = 9;
    localparam int ADDR_W = 17;
    localparam int BURST = 4;
    localparam int MEM_ADDR_W = 19;
    localparam int BEAT_W = 2;
    localparam int RD_LAT = 2;
    localparam logic [3:0] LANE_SEL_IDLE = 4'hF;
endpackage
`default_nettype wire

// ### design/qrsp_lane.sv
`timescale 1ns/1ns
`default_nettype none
module qrsp_lane (
    input wire logic i_sel_n,
    input wire logic [qrsp_pkg::LANE_W-1:0] i_new,
    input wire logic [qrsp_pkg::LANE_W-1:0] i_old,
    output logic [qrsp_pkg::LANE_W-1:0] o_merged
);
    // Unselected lane keeps the stored byte
    assign o_merged = i_sel_n ? i_old : i_new; // R5
endmodule
`default_nettype wire

// ### design/qrsp_core.sv
`timescale 1ns/1ns
`default_nettype none
// The two input clock phases are modelled as alternating i_clock cycles:
// i_phase high marks the positive-clock edge, low the negative-clock edge.
module qrsp_core (
    input wire logic i_clock,
    input wire logic i_resetn,
    input wire logic i_enable,
    input wire logic i_phase,
    input wire logic i_write_port_select_n,
    input wire logic i_read_port_select_n,
    input wire logic [qrsp_pkg::LANES-1:0] i_byte_write_select_n,
    input wire logic [qrsp_pkg::ADDR_W-1:0] i_addr,
    input wire logic [qrsp_pkg::DATA_W-1:0] i_wdata,
    output logic [qrsp_pkg::DATA_W-1:0] o_rdata,
    output logic o_rdata_oe_n,
    output logic o_read_valid_flag
);
    // ==========================================================
    // Pin synchronisers
    logic [1:0] ph_s, wsel_s, rsel_s;
    logic [qrsp_pkg::LANES-1:0] lsel_a, lsel_b;
    logic [qrsp_pkg::ADDR_W-1:0] ad_a, ad_b;
    logic [qrsp_pkg::DATA_W-1:0] wd_a, wd_b;
    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            ph_s <= 2'h0;
            wsel_s <= 2'h3;
            rsel_s <= 2'h3;
            lsel_a <= qrsp_pkg::LANE_SEL_IDLE;
            lsel_b <= qrsp_pkg::LANE_SEL_IDLE;
            ad_a <= '0;
            ad_b <= '0;
            wd_a <= '0;
            wd_b <= '0;
        end else if (i_enable) begin
            ph_s <= {ph_s[0], i_phase};
            wsel_s <= {wsel_s[0], i_write_port_select_n};
            rsel_s <= {rsel_s[0], i_read_port_select_n};
            lsel_a <= i_byte_write_select_n;
            lsel_b <= lsel_a;
            ad_a <= i_addr;
            ad_b <= ad_a;
            wd_a <= i_wdata;
            wd_b <= wd_a;
        end
    end
    wire logic kpos = ph_s[1];
    wire logic wsel_n = wsel_s[1];
    wire logic rsel_n = rsel_s[1];

    // ==========================================================
    // Memory and write port
    logic [qrsp_pkg::DATA_W-1:0] mem [0:(1<<qrsp_pkg::MEM_ADDR_W)-1];
    logic [qrsp_pkg::ADDR_W-1:0] waddr_r, waddr_nxt;
    logic [qrsp_pkg::BEAT_W-1:0] wbeat_r, wbeat_nxt;
    logic wact_r, wact_nxt;
    logic [qrsp_pkg::MEM_ADDR_W-1:0] wloc;
    logic [qrsp_pkg::DATA_W-1:0] wold, wmerge;
    logic wstrobe;

    always_comb begin
        waddr_nxt = waddr_r;
        wbeat_nxt = wbeat_r;
        wact_nxt = wact_r;
        wstrobe = 1'b0;
        if (wact_r) begin
            wstrobe = 1'b1; // R1 R17
            wbeat_nxt = wbeat_r + 2'h1;
            if (wbeat_r == 2'h3) begin
                wact_nxt = 1'b0;
            end
        end
        // Write address only taken when the select is low
        if (kpos && !wsel_n && (!wact_r || wbeat_r == 2'h3)) begin // R2 R11
            wact_nxt = 1'b1;
            waddr_nxt = ad_b; // R9
            wbeat_nxt = 2'h0;
        end
    end
    // Beats follow one phase after the select edge
    assign wloc = {waddr_r, wbeat_r}; // R10
    assign wold = mem[wloc];
    genvar g;
    generate
        for (g = 0; g < qrsp_pkg::LANES; g++) begin : g_lane
            qrsp_lane u_lane (
                .i_sel_n(lsel_b[g]), // R4 R6 R7 R8
                .i_new(wd_b[g*qrsp_pkg::LANE_W +: qrsp_pkg::LANE_W]),
                .i_old(wold[g*qrsp_pkg::LANE_W +: qrsp_pkg::LANE_W]),
                .o_merged(wmerge[g*qrsp_pkg::LANE_W +: qrsp_pkg::LANE_W])
            );
        end
    endgenerate
    always_ff @(posedge i_clock) begin
        // Data is only written during an active burst
        if (i_enable && wstrobe) begin // R3
            mem[wloc] <= wmerge; // R5
        end
    end
    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            waddr_r <= '0;
            wbeat_r <= 2'h0;
            wact_r <= 1'b0;
        end else if (i_enable) begin
            waddr_r <= waddr_nxt;
            wbeat_r <= wbeat_nxt;
            wact_r <= wact_nxt;
        end
    end

    // ==========================================================
    // Read port
    typedef enum logic [1:0] {QRSP_IDLE, QRSP_WAIT, QRSP_BURST} qrsp_rd_t;
    qrsp_rd_t rst_r, rst_nxt;
    logic [qrsp_pkg::ADDR_W-1:0] raddr_r, raddr_nxt;
    logic [qrsp_pkg::BEAT_W-1:0] rbeat_r, rbeat_nxt;
    logic [qrsp_pkg::DATA_W-1:0] rdata_r, rdata_nxt;
    logic roe_n_r, roe_n_nxt, rvld_r, rvld_nxt;
    logic [qrsp_pkg::BEAT_W-1:0] rwait_r, rwait_nxt;
    logic rstart;

    assign rstart = kpos && !rsel_n; // R14 R11
    always_comb begin
        rst_nxt = rst_r;
        raddr_nxt = raddr_r;
        rbeat_nxt = rbeat_r;
        rwait_nxt = rwait_r;
        rdata_nxt = rdata_r;
        roe_n_nxt = roe_n_r;
        rvld_nxt = 1'b0;
        unique case (rst_r)
            QRSP_IDLE: begin
                // Tristate after pending burst drains
                roe_n_nxt = 1'b1; // R13 R15
                if (rstart) begin
                    raddr_nxt = ad_b; // R9
                    rwait_nxt = 2'h0;
                    rst_nxt = QRSP_WAIT;
                end
            end
            QRSP_WAIT: begin
                rwait_nxt = rwait_r + 2'h1;
                if (rwait_r == 2'(qrsp_pkg::RD_LAT - 1)) begin
                    rbeat_nxt = 2'h0;
                    rst_nxt = QRSP_BURST;
                end
            end
            QRSP_BURST: begin
                rdata_nxt = mem[{raddr_r, rbeat_r}]; // R12
                roe_n_nxt = 1'b0;
                rvld_nxt = 1'b1; // R16
                rbeat_nxt = rbeat_r + 2'h1;
                if (rbeat_r == 2'h3) begin // R14
                    rst_nxt = QRSP_IDLE;
                    if (rstart) begin
                        raddr_nxt = ad_b;
                        rwait_nxt = 2'h0;
                        rst_nxt = QRSP_WAIT;
                    end
                end
            end
        endcase
    end
    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            rst_r <= QRSP_IDLE;
            raddr_r <= '0;
            rbeat_r <= 2'h0;
            rwait_r <= 2'h0;
            rdata_r <= '0;
            roe_n_r <= 1'b1;
            rvld_r <= 1'b0;
        end else if (i_enable) begin
            rst_r <= rst_nxt;
            raddr_r <= raddr_nxt;
            rbeat_r <= rbeat_nxt;
            rwait_r <= rwait_nxt;
            rdata_r <= rdata_nxt;
            roe_n_r <= roe_n_nxt;
            rvld_r <= rvld_nxt;
        end
    end
    assign o_rdata = rdata_r;
    assign o_rdata_oe_n = roe_n_r;
    assign o_read_valid_flag = rvld_r;

    // ==========================================================
    // Checks
    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (!i_resetn || !i_enable);
    chk_valid_drives: assert property (o_read_valid_flag |-> !o_rdata_oe_n) // R16
        else $error("valid without drive");
    chk_idle_tristate: assert property (
        rst_r == QRSP_IDLE |=> o_rdata_oe_n) // R13
        else $error("outputs driven while idle");
    chk_burst_four: assert property (
        $rose(o_read_valid_flag) |-> o_read_valid_flag [*4]) // R14
        else $error("burst shorter than four");
    chk_read_lat: assert property (
        rst_r == QRSP_IDLE && rstart |-> ##4 o_read_valid_flag) // R12
        else $error("read latency wrong");
    chk_write_len: assert property (
        $rose(wact_r) |-> wact_r [*4]) // R17
        else $error("write burst shorter");
    chk_write_start: assert property (
        kpos && !wsel_n && !wact_r |=> wact_r && wbeat_r == 2'h0) // R2
        else $error("write not started");
    chk_no_write: assert property (
        (!kpos || wsel_n) && !wact_r |=> !wact_r) // R3
        else $error("write while deselected");
    chk_addr_hold: assert property (
        wact_r && wbeat_r != 2'h3 |=> $stable(waddr_r)) // R11
        else $error("write address changed");
    chk_lane_keep: assert property (
        wstrobe && lsel_b[0] |-> wmerge[8:0] == wold[8:0]) // R5
        else $error("unselected lane altered");
    cov_write: cover property ($rose(wact_r));
    cov_read: cover property ($rose(o_read_valid_flag));
    cov_b2b: cover property (rst_r == QRSP_BURST && rst_nxt == QRSP_WAIT);
endmodule
`default_nettype wire

// ### dv/qrsp_ctrl_model.sv
`timescale 1ns/1ns
`default_nettype none
// =============================================
// Controller side of the port pins
module qrsp_ctrl_model (
    input wire logic i_clock,
    output logic o_phase,
    output logic o_write_port_select_n,
    output logic o_read_port_select_n,
    output logic [3:0] o_byte_write_select_n,
    output logic [16:0] o_addr,
    output logic [35:0] o_wdata
);
    initial begin
        o_phase = 1'b0;
        o_write_port_select_n = 1'b1;
        o_read_port_select_n = 1'b1;
        o_byte_write_select_n = 4'hF;
        o_addr = 17'h00000;
        o_wdata = 36'h000000000;
    end
    // Phase alternates every cycle, like the two input clock edges
    always @(posedge i_clock) o_phase <= #2 ~o_phase;
    // Wait until the cycle just launched is a positive-edge one
    task automatic go_pos();
        @(posedge i_clock);
        while (o_phase !== 1'b0) @(posedge i_clock);
        #2;
    endtask
    task automatic write(input logic [16:0] a, input logic [35:0] d,
        input logic [15:0] b, input logic sel_n);
        go_pos();
        o_write_port_select_n = sel_n;
        o_addr = a;
        for (int k = 0; k < 4; k++) begin
            @(posedge i_clock);
            #2 o_write_port_select_n = 1'b1;
            o_addr = ~a;
            o_wdata = d + 36'(k);
            o_byte_write_select_n = b[4*k+:4];
        end
        @(posedge i_clock);
        // Released bus shows the inverse, never a stale beat
        #2 o_wdata = ~o_wdata;
        o_byte_write_select_n = 4'hF;
    endtask
    task automatic read(input logic [16:0] a);
        go_pos();
        o_read_port_select_n = 1'b0;
        o_addr = a;
        @(posedge i_clock);
        #2 o_read_port_select_n = 1'b1;
        o_addr = ~a;
    endtask
endmodule
`default_nettype wire

// ### dv/quad_rate_sram_port_pins_test.sv
`timescale 1ns/1ns
`default_nettype none
module quad_rate_sram_port_pins_test;
    logic clock = 1'b0;
    logic resetn = 1'b0;
    logic enable = 1'b1;
    logic phase, wsel_n, rsel_n, oe_n, valid;
    logic [3:0] lsel_n;
    logic [16:0] addr;
    logic [35:0] wdata, rdata;
    // Expected words, indexed by address bit 0 and beat
    logic [35:0] exp [0:7];
    int n_mismatch = 0;
    int n_compared = 0;
    always #25 clock = ~clock;
    qrsp_ctrl_model qrsp_ctrl_model_inst (.i_clock(clock), .o_phase(phase),
        .o_write_port_select_n(wsel_n), .o_read_port_select_n(rsel_n),
        .o_byte_write_select_n(lsel_n), .o_addr(addr), .o_wdata(wdata));
    qrsp_core qrsp_core_inst (.i_clock(clock), .i_resetn(resetn),
        .i_enable(enable), .i_phase(phase), .i_write_port_select_n(wsel_n),
        .i_read_port_select_n(rsel_n), .i_byte_write_select_n(lsel_n),
        .i_addr(addr), .i_wdata(wdata), .o_rdata(rdata),
        .o_rdata_oe_n(oe_n), .o_read_valid_flag(valid));
    // =============================================
    // Shared tasks
    task automatic cmp(input logic [35:0] got, input logic [35:0] want);
        n_compared++;
        if (got !== want) begin
            n_mismatch++;
            $display("wrong value at %0t: got %h expected %h", $time, got,
                want);
        end
    endtask
    task automatic end_sim();
        $display("compared %0d, mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic wr(input logic [16:0] a, input logic [35:0] d,
        input logic [15:0] b, input logic sel_n);
        logic [35:0] v;
        qrsp_ctrl_model_inst.write(a, d, b, sel_n);
        for (int k = 0; k < 4; k++) begin
            v = d + 36'(k);
            for (int g = 0; g < 4; g++) begin
                if (sel_n === 1'b0 && b[4*k+g] === 1'b0) begin
                    exp[4*a[0]+k][9*g+:9] = v[9*g+:9];
                end
            end
        end
    endtask
    task automatic rd_check(input logic [16:0] a);
        int t;
        qrsp_ctrl_model_inst.read(a);
        t = 0;
        while (valid !== 1'b1 && t < 20) begin
            @(posedge clock);
            #1 t++;
        end
        cmp(36'(t), 36'h000000005);
        for (int k = 0; k < 4; k++) begin
            cmp(rdata, exp[4*a[0]+k]);
            cmp({35'h0, oe_n}, 36'h000000000);
            @(posedge clock);
            #1;
        end
        cmp({34'h0, oe_n, valid}, 36'h000000002);
    endtask
    // =============================================
    // Scenarios
    task automatic t_full();
        wr(17'h1ABCD, 36'h123456789, 16'h0000, 1'b0);
        wr(17'h05432, 36'h8ABCDEF01, 16'h0000, 1'b0);
        rd_check(17'h1ABCD);
        rd_check(17'h05432);
        $display("test full write done");
    endtask
    task automatic t_lanes();
        // One lane per beat, a different lane each beat
        wr(17'h1ABCD, 36'hFEDCBA987, 16'h7BDE, 1'b0);
        rd_check(17'h1ABCD);
        $display("test byte lanes done");
    endtask
    task automatic t_desel();
        wr(17'h1ABCD, 36'h0F0F0F0F0, 16'h0000, 1'b1);
        rd_check(17'h1ABCD);
        $display("test deselected write done");
    endtask
    task automatic t_b2b();
        // Second read is taken on the last beat of the first burst
        qrsp_ctrl_model_inst.read(17'h05432);
        repeat (4) @(posedge clock);
        qrsp_ctrl_model_inst.read(17'h1ABCD);
        for (int k = 2; k < 4; k++) begin
            @(posedge clock);
            #1 cmp(rdata, exp[k]);
        end
        repeat (3) @(posedge clock);
        #1;
        for (int k = 0; k < 4; k++) begin
            cmp(rdata, exp[4+k]);
            cmp({35'h0, valid}, 36'h000000001);
            @(posedge clock);
            #1;
        end
        cmp({34'h0, oe_n, valid}, 36'h000000002);
        $display("test back to back reads done");
    endtask
    task automatic t_freeze();
        // Enable held low for an even count keeps the phase aligned
        qrsp_ctrl_model_inst.read(17'h1ABCD);
        repeat (5) @(posedge clock);
        #2 cmp(rdata, exp[4]);
        enable = 1'b0;
        repeat (2) @(posedge clock);
        #1 cmp(rdata, exp[4]);
        cmp({34'h0, oe_n, valid}, 36'h000000001);
        #1 enable = 1'b1;
        for (int k = 1; k < 4; k++) begin
            @(posedge clock);
            #1 cmp(rdata, exp[4+k]);
        end
        @(posedge clock);
        #1 cmp({34'h0, oe_n, valid}, 36'h000000002);
        $display("test clock enable freeze done");
    endtask
    // =============================================
    // Main sequence and watchdog
    initial begin
        repeat (20) @(posedge clock);
        #2 resetn = 1'b1;
        cmp(rdata, 36'h000000000);
        cmp({34'h0, oe_n, valid}, 36'h000000002);
        repeat (4) @(posedge clock);
        t_full();
        t_lanes();
        t_desel();
        t_b2b();
        t_freeze();
        end_sim();
    end
    initial begin
        #200000;
        n_mismatch++;
        end_sim();
    end
endmodule
`default_nettype wire
